// ===== logic/board_watchdog_consts.svh
`ifndef BOARD_WATCHDOG_CONSTS_SVH
`define BOARD_WATCHDOG_CONSTS_SVH
`define REG_CTRL        8'h00
`define REG_KICK        8'h04
`define REG_STATUS      8'h08
`define REG_MASK        8'h0c
`define REG_STATE       8'h10
`define REG_IOBASE      8'h14
`define IO_RESOURCE     12'h280
`define CTRL_MODE_LSB   0
`define CTRL_TIME_LSB   2
`define CTRL_ROUTE_LSB  6
`define CTRL_FAILNMI    9
`define CTRL_BOOT       10
`define CTRL_RESET      32'h0000_0000
`define BASE_TIMEOUT_MS 125
`define CLK_MHZ         250
`define NMI_LEAD_US     1000
`define MAX_TIME_SEL    4'hb
`endif

// ===== logic/board_watchdog_pkg.sv
package board_watchdog_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_NMI, MODE_RESET, MODE_CASCADE} wdMode_t;
  typedef enum logic [2:0] {ROUTE_OFF, ROUTE_WDOG, ROUTE_DERATE, ROUTE_ENUM,
                            ROUTE_FAIL} route_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_LEAD, ST_FIRED} wdState_t;
  typedef struct packed {
    logic    bootArm;
    logic    failNmi;
    route_t  route;
    logic [3:0] timeSel;
    wdMode_t mode;
  } ctrl_t;
  typedef struct packed {
    logic derate;
    logic enumSig;
    logic fail;
  } psuIn_t;
endpackage

// ===== logic/board_watchdog_routing.sv
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "board_watchdog_consts.svh"
// What this block does
// (R01) Twelve timeouts, doubling from 125 ms to 256 s.
// (R02) Unretriggered running timer expires and takes action.
// (R03) Action modes: off, NMI, reset, cascade.
// (R04) Boot option starts timer before software runs.
// (R05) Route one chosen source to IRQ5 line.
// (R06) Fail input optionally raises NMI.
// (R07) Hot-swap board pulses enum on insert/remove.
// (R08) Cascade: NMI first, reset after a lead.
module board_watchdog_routing #(
  parameter int unsigned MS_CYCLES   = 250000,
  parameter int unsigned LEAD_CYCLES = `NMI_LEAD_US * `CLK_MHZ
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire board_watchdog_pkg::psuIn_t psuIn,
  input  wire logic                       bootStrap,
  output logic                            irq5,
  output logic                            nmiOut,
  output logic                            resetOut,
  output logic                            intOut
);
  import board_watchdog_pkg::*;
  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);

  ctrl_t            ctrl_ff;
  wdState_t         state_ff;
  logic [2:0]       status_ff;
  logic [2:0]       mask_ff;

  logic [7:0]       addr_ff;
  logic             wr_ff;
  logic             wrAccept;
  logic             rdAccept;
  logic             ctrlWr;
  logic             maskWr;
  logic             kick;
  logic [3:0]       timeSelWr;

  logic             timerRun;
  logic             msTick;
  logic [MS_W-1:0]  msCnt_ff;
  logic [31:0]      timeCnt_ff;
  logic [31:0]      limitMs;
  logic [31:0]      leadCnt_ff;
  logic             leadDone;
  logic             expired;
  logic             bootDone_ff;
  logic             bootArmReq;
  logic             wdogAlert;
  logic             nxt_nmi;
  logic             nxt_reset;
  logic             nxt_irq5;
  logic [2:0]       statusSet;
  logic [31:0]      nxt_rdata;
  logic [31:0]      rdata_ff;

  // The slave never stalls and never errors, so each transfer takes two cycles.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Only single whole-word transfers are taken; other sizes are ignored.
  assign wrAccept = hready && hsel && htrans[1] && hwrite && (hsize == 3'h2);
  assign rdAccept = hready && hsel && htrans[1] && !hwrite && (hsize == 3'h2);

  // Address phase is latched so the data phase can complete in the following cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_ff <= 8'h00;
      wr_ff   <= 1'b0;
    end else if (hready) begin
      addr_ff <= haddr;
      wr_ff   <= wrAccept;
    end
  end

  assign kick   = wr_ff && (addr_ff == `REG_KICK);
  assign ctrlWr = wr_ff && (addr_ff == `REG_CTRL);
  assign maskWr = wr_ff && (addr_ff == `REG_MASK);

  // Settings beyond the longest timeout clamp to it rather than wrap to a short one.
  always_comb begin
    timeSelWr = hwdata[`CTRL_TIME_LSB +: 4];
    if (timeSelWr > `MAX_TIME_SEL) begin
      timeSelWr = `MAX_TIME_SEL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_ff <= ctrl_t'(11'(`CTRL_RESET));
    end else if (ctrlWr) begin
      ctrl_ff.mode    <= wdMode_t'(hwdata[`CTRL_MODE_LSB +: 2]); // [R03]
      ctrl_ff.timeSel <= timeSelWr; // [R01]
      ctrl_ff.route   <= route_t'(hwdata[`CTRL_ROUTE_LSB +: 3]); // [R05]
      ctrl_ff.failNmi <= hwdata[`CTRL_FAILNMI]; // [R06]
      ctrl_ff.bootArm <= hwdata[`CTRL_BOOT];
    end
  end

  // Millisecond enable; 125 ms is the base so every setting is a whole multiple.
  assign timerRun = (state_ff == ST_RUN);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !timerRun || kick) begin
      msCnt_ff <= MS_W'(0);
    end else if (msTick) begin
      msCnt_ff <= MS_W'(0);
    end else begin
      msCnt_ff <= msCnt_ff + MS_W'(1);
    end
  end
  assign msTick = (msCnt_ff == MS_W'(MS_CYCLES - 1));

  assign limitMs = 32'(`BASE_TIMEOUT_MS) << ctrl_ff.timeSel; // [R01]
  assign expired = msTick && (timeCnt_ff + 32'h1 >= limitMs);

  // A kick clears both the fraction and the count, so the full timeout restarts.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !timerRun || kick) begin
      timeCnt_ff <= 32'h0;
    end else if (msTick) begin
      timeCnt_ff <= timeCnt_ff + 32'h1;
    end
  end

  // The control register is cleared by reset, so the boot option comes from a strap pin.
  // It is sampled once after reset release.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bootDone_ff <= 1'b0;
    end else begin
      bootDone_ff <= 1'b1;
    end
  end
  assign bootArmReq = !bootDone_ff && bootStrap;

  // The lead counter only runs in the lead state, so it restarts on every expiry.
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_ff != ST_LEAD) begin
      leadCnt_ff <= 32'h0;
    end else begin
      leadCnt_ff <= leadCnt_ff + 32'h1;
    end
  end
  assign leadDone = (leadCnt_ff == 32'(LEAD_CYCLES - 1));

  // A kick with the mode off stops the timer; any other kick starts or retriggers it, but an expiry in the same cycle wins over it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (bootArmReq) begin
            state_ff <= ST_RUN; // [R04]
          end else if (kick && ctrl_ff.mode != MODE_OFF) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (kick && ctrl_ff.mode == MODE_OFF) begin
            state_ff <= ST_IDLE;
          end else if (expired) begin
            if (ctrl_ff.mode == MODE_CASCADE) begin
              state_ff <= ST_LEAD; // [R08]
            end else begin
              state_ff <= ST_FIRED; // [R02]
            end
          end
        end
        ST_LEAD: begin
          if (kick && ctrl_ff.mode == MODE_OFF) begin
            state_ff <= ST_IDLE;
          end else if (kick) begin
            state_ff <= ST_RUN;
          end else if (leadDone) begin
            state_ff <= ST_FIRED; // [R08]
          end
        end
        ST_FIRED: begin
          if (kick && ctrl_ff.mode == MODE_OFF) begin
            state_ff <= ST_IDLE;
          end else if (kick) begin
            state_ff <= ST_RUN;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // The watchdog alert covers both the lead and the fired state.
  assign wdogAlert = (state_ff == ST_LEAD) || (state_ff == ST_FIRED);

  always_comb begin
    nxt_nmi = 1'b0;
    if (ctrl_ff.mode == MODE_NMI || ctrl_ff.mode == MODE_CASCADE) begin
      nxt_nmi = wdogAlert; // [R03] [R08]
    end
    if (ctrl_ff.failNmi && psuIn.fail) begin
      nxt_nmi = 1'b1; // [R06]
    end
  end

  always_comb begin
    nxt_reset = 1'b0;
    if (ctrl_ff.mode == MODE_RESET || ctrl_ff.mode == MODE_CASCADE) begin
      nxt_reset = (state_ff == ST_FIRED); // [R03]
    end
  end

  // The routed line is only a selection; the status register sees expiry, fail and enum regardless, but not derate.
  always_comb begin
    case (ctrl_ff.route) // [R05]
      ROUTE_WDOG:   nxt_irq5 = wdogAlert;
      ROUTE_DERATE: nxt_irq5 = psuIn.derate;
      ROUTE_ENUM:   nxt_irq5 = psuIn.enumSig; // [R07]
      ROUTE_FAIL:   nxt_irq5 = psuIn.fail;
      default:      nxt_irq5 = 1'b0;
    endcase
  end

  // nmiOut, resetOut and irq5 are registered so a glitch on the mode field cannot pulse reset.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nmiOut   <= 1'b0;
      resetOut <= 1'b0;
      irq5     <= 1'b0;
    end else begin
      nmiOut   <= nxt_nmi;
      resetOut <= nxt_reset;
      irq5     <= nxt_irq5;
    end
  end

  // Status bit 0 expiry, 1 fail, 2 enum; a new event beats the read clear.
  assign statusSet = {psuIn.enumSig, psuIn.fail, expired && timerRun};

  // A read clears status at the edge that captures its data, so no event slips between.
  for (genvar b = 0; b < 3; b++) begin : gStatus
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        status_ff[b] <= 1'b0;
      end else if (statusSet[b]) begin
        status_ff[b] <= 1'b1;
      end else if (rdAccept && haddr == `REG_STATUS) begin
        status_ff[b] <= 1'b0;
      end
    end
  end

  // Mask bits follow the status layout; intOut is high while any set status bit has its mask bit set.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask_ff <= 3'h0;
    end else if (maskWr) begin
      mask_ff <= hwdata[2:0];
    end
  end

  assign intOut = |(status_ff & mask_ff);

  // Read data is picked at the address phase and stands from a flip-flop in the data phase.
  always_comb begin
    nxt_rdata = 32'h0;
    if (haddr == `REG_CTRL) begin
      nxt_rdata = {21'h0, ctrl_ff};
    end else if (haddr == `REG_STATUS) begin
      nxt_rdata = {29'h0, status_ff};
    end else if (haddr == `REG_MASK) begin
      nxt_rdata = {29'h0, mask_ff};
    end else if (haddr == `REG_STATE) begin
      nxt_rdata = {30'h0, state_ff};
    end else if (haddr == `REG_IOBASE) begin
      nxt_rdata = {20'h0, `IO_RESOURCE}; // [R05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0;
    end else if (rdAccept) begin
      rdata_ff <= nxt_rdata;
    end else if (hready) begin
      rdata_ff <= 32'h0;
    end
  end
  assign hrdata = rdata_ff;
endmodule

// ===== test/psu_source.sv
`timescale 1ns/1ns
module psu_source (
  input  wire logic                 core_clk,
  input  wire logic                 inserted,
  input  wire logic                 derate,
  input  wire logic                 fail,
  output board_watchdog_pkg::psuIn_t psuIn
);
  import board_watchdog_pkg::*;
  logic seat_ff = 1'b0;
  // The enum line pulses for one cycle after insertion and again after removal.
  always @(posedge core_clk) begin
    seat_ff <= inserted;
    psuIn   <= '{derate: derate, enumSig: inserted ^ seat_ff, fail: fail};
  end
endmodule

// ===== test/board_watchdog_assertions.sv
`timescale 1ns/1ns
`include "board_watchdog_consts.svh"
module board_watchdog_assertions #(
  parameter int unsigned LEAD_CYCLES = 8
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       hsel,
  input wire logic [7:0]                 haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [2:0]                 hsize,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire board_watchdog_pkg::psuIn_t psuIn,
  input wire logic                       irq5,
  input wire logic                       nmiOut,
  input wire logic                       resetOut
);
  import board_watchdog_pkg::*;
  logic       wrPend_ff;
  logic [7:0] addr_ff;
  ctrl_t      ctrl_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // A shadow of the control word lets each check know the selected mode and route.
  always_ff @(posedge core_clk) begin
    wrPend_ff <= !sys_rst && hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
    addr_ff   <= haddr;
    if (sys_rst) begin
      ctrl_ff <= ctrl_t'(11'h000);
    end else if (wrPend_ff && addr_ff == `REG_CTRL) begin
      ctrl_ff <= ctrl_t'(hwdata[10:0]);
    end
  end
  chk_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus answer not ready or okay");
  chk_reset_quiet:
    assert property ($fell(sys_rst) |-> !nmiOut && !resetOut && !irq5) else $error("out of reset");
  chk_route_off:
    assert property (ctrl_ff.route == ROUTE_OFF |=> !irq5) else $error("irq5 with no route");
  chk_route_derate:
    assert property (ctrl_ff.route == ROUTE_DERATE |=> irq5 == $past(psuIn.derate))
      else $error("irq5 not following derate");
  chk_fail_nmi:
    assert property (ctrl_ff.failNmi && psuIn.fail |=> nmiOut) else $error("fail gave no nmi");
  chk_action_mode:
    assert property ($rose(resetOut) |-> ctrl_ff.mode inside {MODE_RESET, MODE_CASCADE})
      else $error("reset in a mode without reset");
  chk_reset_only:
    assert property ($rose(resetOut) && ctrl_ff.mode == MODE_RESET && !ctrl_ff.failNmi
      |-> !nmiOut) else $error("nmi in reset only mode");
  chk_cascade_lead:
    assert property ($rose(resetOut) && ctrl_ff.mode == MODE_CASCADE
      |-> $past(nmiOut, LEAD_CYCLES - 1)) else $error("cascade reset without nmi lead");
endmodule
bind board_watchdog_routing board_watchdog_assertions #(.LEAD_CYCLES(LEAD_CYCLES))
  board_watchdog_assertions_i (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hreadyout, .hresp, .psuIn, .irq5, .nmiOut, .resetOut);

// ===== test/tb_top.sv
`timescale 1ns/1ns
`include "board_watchdog_consts.svh"
module tb_top;
  import board_watchdog_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        seat = 1'b0, derate = 1'b0, fail = 1'b0, hreadyout, hresp;
  logic        boot = 1'b1;
  logic        irq5, nmiOut, resetOut, intOut;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  pins;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rd, rdHold;
  psuIn_t      psuIn;
  int          errTotal = 0, nCompared = 0;
  always #2 core_clk = ~core_clk;
  // Outputs are taken mid-cycle so no check races the edge that updates them.
  always @(negedge core_clk) begin
    rdHold = hrdata;
    pins   = {irq5, nmiOut, resetOut, intOut};
  end
  psu_source psu_source_i (.core_clk, .inserted(seat), .derate, .fail, .psuIn);
  board_watchdog_routing #(.MS_CYCLES(4), .LEAD_CYCLES(8)) board_watchdog_routing_i (
    .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .psuIn, .bootStrap(boot), .irq5,
    .nmiOut, .resetOut, .intOut);
  task automatic endOfTest;
    if (errTotal == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = rdHold;
  endtask
  initial begin
    wt(6);
    sys_rst <= 1'b0;
    bus(0, `REG_IOBASE, 32'h0); check("iobase", rd, 32'h280);
    bus(0, 8'h3c, 32'h0); check("unmapped", rd, 32'h0);
    bus(0, `REG_STATE, 32'h0); check("boot run", rd, 32'h1);
    bus(1, `REG_MASK, 32'h6);
    bus(1, `REG_CTRL, 32'h80); derate <= 1'b1; wt(3); check("irq5", pins[3], 32'h1);
    bus(1, `REG_CTRL, 32'h200); derate <= 1'b0; fail <= 1'b1; wt(3);
    check("irq5", pins[3], 32'h0); check("nmi", pins[2], 32'h1);
    bus(1, `REG_CTRL, 32'h0); wt(3); check("nmi", pins[2], 32'h0);
    fail <= 1'b0; seat <= 1'b1; wt(3); check("int", pins[0], 32'h1);
    bus(0, `REG_STATUS, 32'h0); check("status", rd, 32'h6);
    bus(0, `REG_STATUS, 32'h0); check("status", rd, 32'h0);
    wt(1); check("int", pins[0], 32'h0);
    for (int s = 0; s < 2; s++) begin
      bus(1, `REG_CTRL, 32'h1 | (s << 2)); bus(1, `REG_KICK, 32'h0);
      wt((500 << s) - 30); check("nmi early", pins[2], 32'h0);
      wt(60); check("nmi late", pins[2], 32'h1);
    end
    bus(1, `REG_CTRL, 32'h43); bus(1, `REG_KICK, 32'h0); wt(3);
    while (pins[2] !== 1'b1) wt(1);
    check("reset lead", pins[1], 32'h0); wt(12); check("reset", pins[1], 32'h1);
    check("irq5 wdog", pins[3], 32'h1);
    bus(1, `REG_CTRL, 32'h2); bus(1, `REG_KICK, 32'h0); wt(3);
    while (pins[1] !== 1'b1) wt(1);
    check("nmi", pins[2], 32'h0);
    bus(1, `REG_CTRL, 32'h0); bus(1, `REG_KICK, 32'h0); wt(600);
    check("off", pins[2:1], 32'h0);
    endOfTest;
  end
  // The tests need under 4000 cycles; a hang is cut off well beyond that.
  initial begin
    wt(20000);
    errTotal++;
    endOfTest;
  end
endmodule
